// ==== logic/mpbrc_top.sv ====
// Reset sequencing, configuration pins and bus request of one processor.
// Assumes pins arrive asynchronously and an AXI4-Lite master on clk_sys_i.
module mpbrc_top
  import mpbrc_pkg::*;
#(
  parameter int          LOCK_CYCLES   = `MPBRC_PLL_LOCK_CYCLES,
  parameter logic [31:0] RESET_VECTOR  = 32'h0000_0000,
  parameter bit          MULTI_VARIANT = 1'b1
) (
  // Clock, reset, enable
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic        clk_en_i,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Configuration pins
  input  wire logic [1:0]  boot_cfg_i,
  input  wire logic [2:0]  processor_number_i,
  input  wire logic        rotating_priority_select_i,
  output logic             pullup_en_o,
  // Bus request lines, active low
  input  wire logic [3:0]  bus_request_lines_i,
  output logic [3:0]       bus_request_lines_o,
  output logic [3:0]       bus_request_lines_oe_o,
  output logic             bus_grant_o,
  // Core reset and start
  output logic             core_reset_drive_o,
  output logic             core_start_o,
  output logic [31:0]      fetch_addr_o
);

  localparam logic [`MPBRC_LOCK_CNT_W-1:0] LOCK_LAST =
    `MPBRC_LOCK_CNT_W'(LOCK_CYCLES - 1);

  // Line select from processor number, none for reserved codes
  function automatic logic [3:0] own_line(input logic [2:0] num);
    if (num == `MPBRC_ID_SINGLE) begin
      own_line = 4'h1;
    end else if (num <= `MPBRC_ID_LAST) begin
      own_line = 4'h1 << (num - 3'h1);
    end else begin
      own_line = 4'h0;
    end
  endfunction

  mpbrc_arb_if arb_if ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser, change taken when stages two and three agree
  logic [`MPBRC_SYNC_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;

  always_comb begin
    filt_next = filt_reg;
    for (int i = 0; i < `MPBRC_SYNC_W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        filt_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_reg   <= `MPBRC_SYNC_RST;
      s2_reg   <= `MPBRC_SYNC_RST;
      s3_reg   <= `MPBRC_SYNC_RST;
      filt_reg <= `MPBRC_SYNC_RST;
    end else if (clk_en_i) begin
      s1_reg   <= {boot_cfg_i, processor_number_i,
                   rotating_priority_select_i, bus_request_lines_i};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer and strap capture
  mpbrc_state_t                  state_reg, state_next;
  logic [`MPBRC_LOCK_CNT_W-1:0]  cnt_reg, cnt_next;
  logic [2:0]                    id_reg, id_next;
  logic [1:0]                    boot_reg, boot_next;
  logic                          start_reg, start_next;
  logic                          run;

  assign run = (state_reg == MPBRC_ST_RUN);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    id_next    = id_reg;
    boot_next  = boot_reg;
    start_next = 1'b0;
    case (state_reg)
      MPBRC_ST_LOCK: begin
        id_next   = filt_reg[7:5];
        boot_next = filt_reg[9:8];
        if (cnt_reg == LOCK_LAST) begin
          state_next = MPBRC_ST_RUN;
          start_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + `MPBRC_LOCK_CNT_W'(1);
        end
      end
      MPBRC_ST_RUN: begin
        state_next = MPBRC_ST_RUN;
      end
      default: begin
        state_next = MPBRC_ST_LOCK;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= MPBRC_ST_LOCK;
      cnt_reg   <= '0;
      id_reg    <= 3'h0;
      boot_reg  <= 2'h0;
      start_reg <= 1'b0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      id_reg    <= id_next;
      boot_reg  <= boot_next;
      start_reg <= start_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic        aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic        wstrb0_reg, wstrb0_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        req_reg, req_next;
  logic [31:0] status;

  // Status word assembled from live block state
  always_comb begin
    status = 32'h0;
    status[`MPBRC_ST_RUN_BIT]    = run;
    status[`MPBRC_ST_GRANT_BIT]  = bus_grant_o;
    status[`MPBRC_ST_PULLUP_BIT] = pullup_en_o;
    status[`MPBRC_ST_ROT_BIT]    = filt_reg[4];
    status[`MPBRC_ST_ID_LSB  +: 3] = id_reg;
    status[`MPBRC_ST_BOOT_LSB +: 2] = boot_reg;
    status[`MPBRC_ST_REQS_LSB +: 4] = arb_if.req;
    status[`MPBRC_ST_OWNER_LSB +: 4] = arb_if.owner;
  end

  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next  = wdata_reg;
    wstrb0_next = wstrb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    req_next    = req_reg;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_got_next  = 1'b1;
      wdata_next  = s_axi_wdata_i;
      wstrb0_next = s_axi_wstrb_i[0];
    end
    if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    if (aw_got_reg && w_got_reg) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = `MPBRC_RESP_OKAY;
      if (awaddr_reg == `MPBRC_OFS_CTRL) begin
        if (wstrb0_reg) begin
          req_next = wdata_reg[`MPBRC_CTRL_REQ_BIT];
        end
      end else if (awaddr_reg == `MPBRC_OFS_STATUS ||
                   awaddr_reg == `MPBRC_OFS_VECTOR) begin
        bresp_next = `MPBRC_RESP_OKAY; // Read-only, write ignored
      end else begin
        bresp_next = `MPBRC_RESP_SLVERR;
      end
    end
    if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_next = 1'b1;
      rresp_next  = `MPBRC_RESP_OKAY;
      rdata_next  = 32'h0;
      if (s_axi_araddr_i == `MPBRC_OFS_CTRL) begin
        rdata_next[`MPBRC_CTRL_REQ_BIT] = req_reg;
      end else if (s_axi_araddr_i == `MPBRC_OFS_STATUS) begin
        rdata_next = status;
      end else if (s_axi_araddr_i == `MPBRC_OFS_VECTOR) begin
        rdata_next = RESET_VECTOR;
      end else begin
        rresp_next = `MPBRC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_got_reg      <= 1'b0;
      w_got_reg       <= 1'b0;
      awaddr_reg      <= 8'h00;
      wdata_reg       <= 32'h0;
      wstrb0_reg      <= 1'b0;
      bvalid_reg      <= 1'b0;
      bresp_reg       <= `MPBRC_RESP_OKAY;
      rvalid_reg      <= 1'b0;
      rresp_reg       <= `MPBRC_RESP_OKAY;
      rdata_reg       <= 32'h0;
      req_reg         <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_arready_o <= 1'b0;
    end else if (clk_en_i) begin
      aw_got_reg      <= aw_got_next;
      w_got_reg       <= w_got_next;
      awaddr_reg      <= awaddr_next;
      wdata_reg       <= wdata_next;
      wstrb0_reg      <= wstrb0_next;
      bvalid_reg      <= bvalid_next;
      bresp_reg       <= bresp_next;
      rvalid_reg      <= rvalid_next;
      rresp_reg       <= rresp_next;
      rdata_reg       <= rdata_next;
      req_reg         <= req_next;
      s_axi_awready_o <= !aw_got_next && !bvalid_next;
      s_axi_wready_o  <= !w_got_next && !bvalid_next;
      s_axi_arready_o <= !rvalid_next;
    end
  end

  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o  = bresp_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rresp_o  = rresp_reg;
  assign s_axi_rdata_o  = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus request lines and arbitration
  logic [3:0] own;
  logic       own_req;

  assign own     = own_line(id_reg);
  assign own_req = req_reg && run && (own != 4'h0);

  // Others' lines monitored, own line from internal request
  assign arb_if.req    = (~filt_reg[3:0] & ~own) |
                         (own & {4{own_req}});
  assign arb_if.rotate = filt_reg[4];
  assign arb_if.enable = run;

  mpbrc_arb u_arb (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .clk_en_i  (clk_en_i),
    .arb       (arb_if.arb)
  );

  // Registered pin outputs
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_request_lines_o    <= 4'hF;
      bus_request_lines_oe_o <= 4'h0;
      bus_grant_o            <= 1'b0;
      pullup_en_o            <= 1'b1;
      core_reset_drive_o     <= 1'b0;
      core_start_o           <= 1'b0;
      fetch_addr_o           <= 32'h0;
    end else if (clk_en_i) begin
      bus_request_lines_o    <= ~(own & {4{own_req}});
      bus_request_lines_oe_o <= own & {4{run}};
      bus_grant_o            <= |(arb_if.owner & own);
      pullup_en_o            <= !MULTI_VARIANT ||
                                (id_reg[2:1] == 2'h0);
      core_reset_drive_o     <= run || start_next;
      core_start_o           <= start_next;
      fetch_addr_o           <= RESET_VECTOR;
    end
  end

endmodule // mpbrc_top

// ==== logic/mpbrc_defs.svh ====
// Constants of the bus-request and reset configuration block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef MPBRC_DEFS_SVH
`define MPBRC_DEFS_SVH

// Wait after reset release, in input-clock cycles
`define MPBRC_PLL_LOCK_CYCLES   4096
`define MPBRC_LOCK_CNT_W        13

// Register byte offsets
`define MPBRC_OFS_CTRL          8'h00
`define MPBRC_OFS_STATUS        8'h04
`define MPBRC_OFS_VECTOR        8'h08

// Control register fields
`define MPBRC_CTRL_REQ_BIT      0

// Status register fields
`define MPBRC_ST_RUN_BIT        0
`define MPBRC_ST_GRANT_BIT      1
`define MPBRC_ST_PULLUP_BIT     2
`define MPBRC_ST_ROT_BIT        3
`define MPBRC_ST_ID_LSB         4
`define MPBRC_ST_BOOT_LSB       8
`define MPBRC_ST_REQS_LSB       12
`define MPBRC_ST_OWNER_LSB      16

// AXI responses
`define MPBRC_RESP_OKAY         2'h0
`define MPBRC_RESP_SLVERR       2'h2

// Pin synchroniser: reset value, bus-request lines idle high
`define MPBRC_SYNC_RST          10'h00F
`define MPBRC_SYNC_W            10

// Processor-number codes
`define MPBRC_ID_SINGLE         3'h0
`define MPBRC_ID_LAST           3'h4

`endif

// ==== logic/mpbrc_pkg.sv ====
// Types shared by the bus-request and reset configuration block.
// Assumes nothing beyond the defines header.
package mpbrc_pkg;
  `include "mpbrc_defs.svh"

  // Reset sequencer states, one-hot
  typedef enum logic [1:0] {
    MPBRC_ST_LOCK = 2'h1,
    MPBRC_ST_RUN  = 2'h2
  } mpbrc_state_t;
endpackage

// ==== logic/mpbrc_arb_if.sv ====
// Signals between the configuration top and its bus arbiter.
// Assumes both ends sit on the same clock.
interface mpbrc_arb_if;
  logic [3:0] req;      // Active-high requests, line 1 at bit 0
  logic       rotate;   // Rotating priority selected
  logic       enable;   // Arbitration running
  logic [3:0] owner;    // One-hot current bus owner

  modport arb (input req, rotate, enable, output owner);
  modport top (output req, rotate, enable, input owner);
endinterface

// ==== logic/mpbrc_arb.sv ====
// Bus-ownership arbiter over four request lines.
// Assumes requests are already synchronised to clk_sys_i.
module mpbrc_arb
  import mpbrc_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  input  wire logic clk_en_i,
  // Arbiter link
  mpbrc_arb_if.arb  arb
);

  logic [3:0] owner_reg, owner_next;
  logic [1:0] ptr_reg, ptr_next;

  ////////////////////////////////////////////////////////////////////////////
  // Keep owner while it requests, else pick the next one
  always_comb begin
    logic [1:0] base;
    logic [1:0] idx;
    logic       found;
    base       = 2'h0;
    idx        = 2'h0;
    found      = 1'b0;
    owner_next = owner_reg;
    ptr_next   = ptr_reg;
    if (!arb.enable) begin
      owner_next = 4'h0;
    end else if ((owner_reg & arb.req) == 4'h0) begin
      owner_next = 4'h0;
      base = arb.rotate ? ptr_reg + 2'h1 : 2'h0;
      for (int i = 0; i < 4; i++) begin
        idx = base + i[1:0];
        if (!found && arb.req[idx]) begin
          found      = 1'b1;
          owner_next = 4'h1 << idx;
          ptr_next   = idx;
        end
      end
    end
  end

  // Owner and rotation pointer registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      owner_reg <= 4'h0;
      ptr_reg   <= 2'h3;
    end else if (clk_en_i) begin
      owner_reg <= owner_next;
      ptr_reg   <= ptr_next;
    end
  end

  assign arb.owner = owner_reg;

endmodule // mpbrc_arb

// ==== sim/mpbrc_props.sv ====
// Port checker for the reset and bus-request configuration block.
// Assumes it is bound onto mpbrc_top with the same parameters.
module mpbrc_props #(
  parameter int          LOCK_CYCLES   = 4096,
  parameter logic [31:0] RESET_VECTOR  = 32'h0000_0000,
  parameter bit          MULTI_VARIANT = 1'b1
) (
  // Clock, reset, enable
  input wire logic        clk_sys_i,
  input wire logic        arst_n_i,
  input wire logic        clk_en_i,
  // Pins and core outputs
  input wire logic [2:0]  processor_number_i,
  input wire logic        pullup_en_o,
  input wire logic [3:0]  bus_request_lines_o,
  input wire logic [3:0]  bus_request_lines_oe_o,
  input wire logic        bus_grant_o,
  input wire logic        core_reset_drive_o,
  input wire logic        core_start_o,
  input wire logic [31:0] fetch_addr_o,
  // Write response
  input wire logic        s_axi_bvalid_o,
  input wire logic [1:0]  s_axi_bresp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_reg;
  int cnt_next;

  // Request line owned by a processor number, none when reserved
  function automatic logic [3:0] line_of(input logic [2:0] n);
    return (n == 3'h0) ? 4'h1 : 4'h1 << (n - 3'h1);
  endfunction

  // Enabled edges since reset release, saturating
  always_comb begin
    cnt_next = cnt_reg;
    if (clk_en_i && cnt_reg < LOCK_CYCLES) cnt_next = cnt_reg + 1;
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) cnt_reg <= 0;
    else cnt_reg <= cnt_next;
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  chk_lock_wait: assert property (
    $rose(core_reset_drive_o) |-> cnt_reg == LOCK_CYCLES)
    else $error("core released at wrong edge count");
  chk_rst_hold: assert property (
    core_reset_drive_o |=> core_reset_drive_o)
    else $error("reset output fell without reset");
  chk_start_pulse: assert property (
    core_start_o |-> $rose(core_reset_drive_o) ##1 !core_start_o)
    else $error("start pulse malformed");
  chk_fetch_vec: assert property (
    core_start_o |-> fetch_addr_o == RESET_VECTOR)
    else $error("fetch not at reset vector");
  chk_idle_lock: assert property (
    !core_reset_drive_o |-> bus_request_lines_oe_o == 4'h0)
    else $error("request line driven during lock");
  chk_own_line: assert property (
    bus_request_lines_oe_o != 4'h0
      |-> bus_request_lines_oe_o == line_of(processor_number_i))
    else $error("drive on a line not owned");
  chk_grant_req: assert property (
    $rose(bus_grant_o)
      |-> |(bus_request_lines_oe_o & ~bus_request_lines_o))
    else $error("grant without own request");
  chk_pullup_id: assert property (
    core_reset_drive_o && $past(core_reset_drive_o) |-> pullup_en_o ==
      (!MULTI_VARIANT || processor_number_i[2:1] == 2'h0))
    else $error("pull-up enable wrong for number");

  // Main scenarios reached
  cov_start: cover property (core_start_o);
  cov_grant: cover property ($rose(bus_grant_o));
  cov_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
endmodule // mpbrc_props

bind mpbrc_top mpbrc_props #(
  .LOCK_CYCLES(LOCK_CYCLES),
  .RESET_VECTOR(RESET_VECTOR),
  .MULTI_VARIANT(MULTI_VARIANT)
) u_props (.*);

// ==== sim/mpbrc_peers.sv ====
// Peer processors on the shared active-low request lines.
// Assumes the bench commands which peers request, by clock edge.
module mpbrc_peers (
  // Commands from the bench, active high
  input  wire logic [3:0] peer_req_i,
  // Device drive of its own line
  input  wire logic [3:0] dev_lines_i,
  input  wire logic [3:0] dev_oe_i,
  // Resolved wire levels
  output logic [3:0]      lines_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Own line left to the device, idle lines pulled high
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (dev_oe_i[i]) lines_o[i] = dev_lines_i[i];
      else lines_o[i] = ~peer_req_i[i];
    end
  end
endmodule // mpbrc_peers

// ==== sim/tb.sv ====
// Self-checking bench of the reset and bus-request block.
// Assumes the peer model and the bound port checker.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          LOCK = 8;
  localparam logic [31:0] VECT = 32'h0000_1000;
  localparam logic [2:0]  NUMS [7] = '{3'h5, 3'h7, 3'h2, 3'h3, 3'h4,
                                       3'h0, 3'h1};
  localparam logic [3:0]  OES [7] = '{4'h0, 4'h0, 4'h2, 4'h4, 4'h8,
                                      4'h1, 4'h1};
  localparam logic        PULL [7] = '{0, 0, 0, 0, 0, 1, 1};
  // Design inputs, reset low from time zero
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, clk_en_i = 1'b1;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0000_0000;
  logic [3:0] s_axi_wstrb_i = 4'hF, peer_req = 4'h0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0, rotating_priority_select_i = 1'b0;
  logic [1:0] boot_cfg_i = 2'h0;
  logic [2:0] processor_number_i = 3'h0;
  // Design outputs
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_arready_o, s_axi_rvalid_o, pullup_en_o, bus_grant_o;
  logic core_reset_drive_o, core_start_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o, fetch_addr_o, rd_data;
  logic [3:0] bus_request_lines_o, bus_request_lines_oe_o;
  wire logic [3:0] bus_request_lines_i;
  int bad_count = 0;
  int compares = 0;

  // Clock of 50 ns
  always #25 clk_sys_i = ~clk_sys_i;

  mpbrc_top #(.LOCK_CYCLES(LOCK), .RESET_VECTOR(VECT)) DUT (.*);
  mpbrc_peers u_peers (
    .peer_req_i(peer_req),
    .dev_lines_i(bus_request_lines_o),
    .dev_oe_i(bus_request_lines_oe_o),
    .lines_o(bus_request_lines_i)
  );

  ////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic hang(input string nm);
    chk(nm, 32'h0000_0000, 32'h0000_0001);
    final_report();
  endtask

  task automatic ticks(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    bit done;
    done = 1'b0;
    // One edge apart from the last transfer, so bready is not set twice
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wdata_i <= d;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o && s_axi_awvalid_i) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o && s_axi_wvalid_i) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o === 1'b1) begin
        done = 1'b1;
        s_axi_bready_i <= 1'b0;
        chk("bresp", s_axi_bresp_o, er);
      end
    end
    if (!done) hang("bvalid");
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
    bit done;
    done = 1'b0;
    // One edge apart from the last transfer, so rready is not set twice
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o && s_axi_arvalid_i) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o === 1'b1) begin
        done = 1'b1;
        s_axi_rready_i <= 1'b0;
        rd_data = s_axi_rdata_o;
        chk("rresp", s_axi_rresp_o, er);
      end
    end
    if (!done) hang("rvalid");
  endtask

  ////////////////////////////////////////////////////////////////////
  // Reset with new straps, then time the lock wait
  // The enable is held low for the first fz edges after release
  task automatic do_reset(input logic [2:0] num, input int fz);
    int n;
    boot_cfg_i <= num[1:0];
    @(posedge clk_sys_i);
    arst_n_i <= 1'b0;
    @(posedge clk_sys_i);
    processor_number_i <= num;
    ticks(18);
    arst_n_i <= 1'b1;
    if (fz > 0) clk_en_i <= 1'b0;
    for (n = 0; n < 40 && core_start_o !== 1'b1; n++) begin
      @(posedge clk_sys_i);
      if (n == fz - 1) clk_en_i <= 1'b1;
      if (core_start_o !== 1'b1) chk("rst_out", core_reset_drive_o, 0);
    end
    if (n == 40) hang("start");
    chk("lock_wait", n, LOCK + 1 + fz);
    chk("rst_out", core_reset_drive_o, 1'b1);
    chk("fetch", fetch_addr_o, VECT);
  endtask

  // Straps decode, own line drive and pull-up choice
  task automatic t_config(input logic [2:0] num, input logic [3:0] oe,
                          input logic pull);
    do_reset(num, (num == 3'h3) ? 3 : 0);
    axi_rd(8'h04, 2'h0);
    chk("status", rd_data & 32'h0000_0375, {22'h0, num[1:0], 1'b0, num,
        1'b0, pull, 1'b0, 1'b1});
    axi_wr(8'h00, 32'h0000_0001, 2'h0);
    ticks(6);
    chk("drive_en", bus_request_lines_oe_o, oe);
    chk("wire", bus_request_lines_i, {~oe});
    chk("grant", bus_grant_o, |oe);
    chk("pullup", pullup_en_o, pull);
    axi_wr(8'h00, 32'h0000_0000, 2'h0);
  endtask

  // Register access kinds and an unmapped address
  task automatic t_regs();
    axi_wr(8'h00, 32'h0000_0001, 2'h0);
    axi_rd(8'h00, 2'h0);
    chk("ctrl", rd_data[0], 1'b1);
    axi_rd(8'h08, 2'h0);
    chk("vector", rd_data, VECT);
    axi_wr(8'h04, 32'hFFFF_FFFF, 2'h0);
    axi_wr(8'h0C, 32'h0000_0001, 2'h2);
    axi_rd(8'h0C, 2'h2);
    chk("unmapped", rd_data, 32'h0000_0000);
    axi_wr(8'h00, 32'h0000_0000, 2'h0);
    axi_rd(8'h00, 2'h0);
    chk("ctrl", rd_data[0], 1'b0);
    // Lowest strobe bit clear leaves the request untouched
    s_axi_wstrb_i <= 4'hE;
    axi_wr(8'h00, 32'h0000_0001, 2'h0);
    s_axi_wstrb_i <= 4'hF;
    axi_rd(8'h00, 2'h0);
    chk("ctrl_strb", rd_data[0], 1'b0);
  endtask

  // Line 2 parks, then hands over to line 1 or line 3 by mode
  task automatic t_arb(input logic rot);
    rotating_priority_select_i <= rot;
    peer_req <= 4'b0010;
    ticks(8);
    axi_wr(8'h00, 32'h0000_0001, 2'h0);
    peer_req <= 4'b0110;
    ticks(8);
    chk("parked", bus_grant_o, 1'b0);
    peer_req <= 4'b0100;
    ticks(8);
    chk("handover", bus_grant_o, !rot);
    axi_rd(8'h04, 2'h0);
    chk("rot_sel", rd_data[3], rot);
    chk("reqs", rd_data[15:12], 4'h5);
    chk("owner", rd_data[19:16], rot ? 4'h4 : 4'h1);
    peer_req <= 4'b0000;
    axi_wr(8'h00, 32'h0000_0000, 2'h0);
    ticks(8);
  endtask

  // Main sequence
  initial begin
    for (int i = 0; i < 7; i++) t_config(NUMS[i], OES[i], PULL[i]);
    t_regs();
    t_arb(1'b0);
    t_arb(1'b1);
    final_report();
  end
endmodule // tb
